/* psel_pkg.sv */
// How it works
// - Port A bit0 code 01 gives UART receive
// - Port A bit7 selects GPIO/timer/analog2/amp1 inverting
// - Port A bit6 selects GPIO/analog0/amp1 output
// - Small variant: port A high bits 3..0 zero
// - Port B bit3 selects GPIO/analog1/amp1 non-inverting
// - Port B bit1 selects IRQ1 GPIO/analog4/crystal out
// - Port B bit0 selects IRQ0/periodic timer/analog3/crystal
// - Port B bit4 selects GPIO/clock out/amp0 output
// - Clock output held high while clock disabled
// - Larger: port B bit6 LCD1/SDA/UART receive
// - Larger: port B bit5 LCD2/UART transmit/analog7
// - Small variant: port B high bits 7..2 zero
// - Small: port C bit2 code 01 SPI clock
// - Port C bit1 selects GPIO/SPI out/oscillator 2
// - Port C bit0 selects GPIO/chip select/oscillator 1
package psel_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_PORTA_SEL_LO = 8'h00;
  localparam logic [7:0] OFS_PORTA_SEL_HI = 8'h04;
  localparam logic [7:0] OFS_PORTB_SEL_LO = 8'h08;
  localparam logic [7:0] OFS_PORTB_SEL_HI = 8'h0C;
  localparam logic [7:0] OFS_PORTC_SEL_LO = 8'h10;
  localparam int NUM_REGS = 5;
  // Register indices
  localparam logic [2:0] IDX_PA_LO = 3'h0;
  localparam logic [2:0] IDX_PA_HI = 3'h1;
  localparam logic [2:0] IDX_PB_LO = 3'h2;
  localparam logic [2:0] IDX_PB_HI = 3'h3;
  localparam logic [2:0] IDX_PC_LO = 3'h4;
  localparam logic [7:0] SEL_RESET = 8'h00;
  // Implemented bits per variant
  localparam logic [7:0] MASK_SMALL [NUM_REGS] = '{8'h3F, 8'hF0, 8'hCF, 8'h03, 8'h3F};
  localparam logic [7:0] MASK_FULL [NUM_REGS] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF};
  // Field low bit positions
  localparam int LSB_PA0 = 0;
  localparam int LSB_PA6 = 4;
  localparam int LSB_PA7 = 6;
  localparam int LSB_PB0 = 0;
  localparam int LSB_PB1 = 2;
  localparam int LSB_PB3 = 6;
  localparam int LSB_PB4 = 0;
  localparam int LSB_PB5 = 2;
  localparam int LSB_PB6 = 4;
  localparam int LSB_PC0 = 0;
  localparam int LSB_PC1 = 2;
  localparam int LSB_PC2 = 4;
  // Field codes
  localparam logic [1:0] CODE0 = 2'h0;
  localparam logic [1:0] CODE1 = 2'h1;
  localparam logic [1:0] CODE2 = 2'h2;
  localparam logic [1:0] CODE3 = 2'h3;
  // Pad indices
  localparam int NUM_PINS = 12;
  localparam int P_A0 = 0;
  localparam int P_A6 = 1;
  localparam int P_A7 = 2;
  localparam int P_B0 = 3;
  localparam int P_B1 = 4;
  localparam int P_B3 = 5;
  localparam int P_B4 = 6;
  localparam int P_B5 = 7;
  localparam int P_B6 = 8;
  localparam int P_C0 = 9;
  localparam int P_C1 = 10;
  localparam int P_C2 = 11;
  // Amplifier terminal bits
  localparam int AMP1_INV = 0;
  localparam int AMP1_NONINV = 1;
  localparam int AMP1_OUT = 2;
  localparam int AMP0_OUT = 3;
endpackage

/* psel_pin_mux.sv */
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module psel_pin_mux #(
  parameter bit SMALL_VARIANT = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [11:0] padIn,
  output logic [11:0] padOut,
  output logic [11:0] padOe,
  output logic [11:0] padAnalog,
  input wire logic [11:0] gpioOut,
  input wire logic [11:0] gpioOe,
  output logic [11:0] gpioIn,
  output logic [7:0] analogEnable,
  output logic [3:0] ampEnable,
  output logic lowspeedCrystalEnable,
  output logic hsCrystalEnable,
  input wire logic uartTx,
  input wire logic stdTimer0Out,
  input wire logic periodicTimer0Out,
  input wire logic lcdCommon1,
  input wire logic lcdCommon2,
  input wire logic sysClkLevel,
  input wire logic sysClkEnable,
  input wire logic spiDataOut,
  input wire logic spiChipSelN,
  input wire logic spiClkOut,
  input wire logic spiClkOe,
  input wire logic spiDataOe,
  output logic uartRx,
  output logic extIrqLine0,
  output logic extIrqLine1,
  output logic periodicTimer0ClockIn,
  output logic extResetPinN,
  output logic spiClkIn,
  output logic spiDataIn
);

  // Field extraction, used for every pin
  function automatic logic [1:0] fieldOf(input logic [7:0] r, input int lsb);
    fieldOf = r[lsb +: 2];
  endfunction

  // Offset to register index, shared by read and write paths
  function automatic logic [2:0] regIndex(input logic [7:0] a);
    case (a)
      psel_pkg::OFS_PORTA_SEL_LO: regIndex = psel_pkg::IDX_PA_LO;
      psel_pkg::OFS_PORTA_SEL_HI: regIndex = psel_pkg::IDX_PA_HI;
      psel_pkg::OFS_PORTB_SEL_LO: regIndex = psel_pkg::IDX_PB_LO;
      psel_pkg::OFS_PORTB_SEL_HI: regIndex = psel_pkg::IDX_PB_HI;
      default: regIndex = psel_pkg::IDX_PC_LO;
    endcase
  endfunction

  function automatic logic regHit(input logic [7:0] a);
    regHit = (a == psel_pkg::OFS_PORTA_SEL_LO) || (a == psel_pkg::OFS_PORTA_SEL_HI) ||
             (a == psel_pkg::OFS_PORTB_SEL_LO) || (a == psel_pkg::OFS_PORTB_SEL_HI) ||
             (a == psel_pkg::OFS_PORTC_SEL_LO);
  endfunction

  logic [7:0] sel_reg [psel_pkg::NUM_REGS];
  logic [7:0] sel_next [psel_pkg::NUM_REGS];
  logic wrPend_reg;
  logic wrHit_reg;
  logic [2:0] wrIdx_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic addrPhase;
  logic [2:0] addrIdx;
  logic addrHit;

  // Bus decode; zero wait states, always OKAY
  assign addrPhase = hsel && hready && htrans[1];
  assign addrIdx = regIndex(haddr);
  assign addrHit = regHit(haddr);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // Write lands in the data phase; unimplemented bits masked off
  genvar gr;
  generate
    for (gr = 0; gr < psel_pkg::NUM_REGS; gr++) begin : g_reg
      localparam logic [7:0] MASK = SMALL_VARIANT ? psel_pkg::MASK_SMALL[gr] :
                                                    psel_pkg::MASK_FULL[gr];
      assign sel_next[gr] = (wrPend_reg && wrHit_reg && (wrIdx_reg == 3'(gr))) ?
                            (hwdata[7:0] & MASK) : sel_reg[gr];
      always_ff @(posedge core_clk) begin
        if (reset) begin
          sel_reg[gr] <= psel_pkg::SEL_RESET;
        end else begin
          sel_reg[gr] <= sel_next[gr];
        end
      end
    end
  endgenerate

  // Read sees a write still in its data phase, so back-to-back is safe
  assign rdata_next = (addrPhase && !hwrite) ?
                      (addrHit ? {24'h000000, sel_next[addrIdx]} : 32'h00000000) : rdata_reg;

  // Bus pipeline registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPend_reg <= 1'b0;
      wrHit_reg <= 1'b0;
      wrIdx_reg <= 3'h0;
      rdata_reg <= 32'h00000000;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      wrHit_reg <= addrHit;
      wrIdx_reg <= addrIdx;
      rdata_reg <= rdata_next;
    end
  end

  // Field codes per pin
  logic [1:0] selA0, selA6, selA7, selB0, selB1, selB3, selB4, selB5, selB6;
  logic [1:0] selC0, selC1, selC2;
  assign selA0 = fieldOf(sel_reg[psel_pkg::IDX_PA_LO], psel_pkg::LSB_PA0);
  assign selA6 = fieldOf(sel_reg[psel_pkg::IDX_PA_HI], psel_pkg::LSB_PA6);
  assign selA7 = fieldOf(sel_reg[psel_pkg::IDX_PA_HI], psel_pkg::LSB_PA7);
  assign selB0 = fieldOf(sel_reg[psel_pkg::IDX_PB_LO], psel_pkg::LSB_PB0);
  assign selB1 = fieldOf(sel_reg[psel_pkg::IDX_PB_LO], psel_pkg::LSB_PB1);
  assign selB3 = fieldOf(sel_reg[psel_pkg::IDX_PB_LO], psel_pkg::LSB_PB3);
  assign selB4 = fieldOf(sel_reg[psel_pkg::IDX_PB_HI], psel_pkg::LSB_PB4);
  // Fields absent in the small variant are forced to GPIO
  assign selB5 = SMALL_VARIANT ? psel_pkg::CODE0 :
                 fieldOf(sel_reg[psel_pkg::IDX_PB_HI], psel_pkg::LSB_PB5);
  assign selB6 = SMALL_VARIANT ? psel_pkg::CODE0 :
                 fieldOf(sel_reg[psel_pkg::IDX_PB_HI], psel_pkg::LSB_PB6);
  assign selC0 = fieldOf(sel_reg[psel_pkg::IDX_PC_LO], psel_pkg::LSB_PC0);
  assign selC1 = fieldOf(sel_reg[psel_pkg::IDX_PC_LO], psel_pkg::LSB_PC1);
  assign selC2 = SMALL_VARIANT ? fieldOf(sel_reg[psel_pkg::IDX_PC_LO], psel_pkg::LSB_PC2) :
                 psel_pkg::CODE0;

  logic clkOutLevel;
  assign clkOutLevel = sysClkEnable ? sysClkLevel : 1'b1;

  logic [11:0] padOutNext, padOeNext, padAnalogNext, gpioInNext;
  logic [7:0] analogNext;
  logic [3:0] ampNext;
  logic lsXtalNext, hsXtalNext;

  // Pad routing: each pin starts as GPIO, then the field overrides it
  always_comb begin
    padOutNext = gpioOut;
    padOeNext = gpioOe;
    padAnalogNext = 12'h000;
    gpioInNext = padIn;
    analogNext = 8'h00;
    ampNext = 4'h0;
    lsXtalNext = 1'b0;
    hsXtalNext = 1'b0;
    if (selA0 == psel_pkg::CODE1) begin
      padOeNext[psel_pkg::P_A0] = 1'b0;
    end
    case (selA7)
      psel_pkg::CODE1: begin
        padOutNext[psel_pkg::P_A7] = stdTimer0Out;
        padOeNext[psel_pkg::P_A7] = 1'b1;
      end
      psel_pkg::CODE2: analogNext[2] = 1'b1;
      psel_pkg::CODE3: ampNext[psel_pkg::AMP1_INV] = 1'b1;
      default: ;
    endcase
    case (selA6)
      psel_pkg::CODE1: analogNext[0] = 1'b1;
      psel_pkg::CODE2: ampNext[psel_pkg::AMP1_OUT] = 1'b1;
      default: ;
    endcase
    case (selB3)
      psel_pkg::CODE1: analogNext[1] = 1'b1;
      psel_pkg::CODE2: ampNext[psel_pkg::AMP1_NONINV] = 1'b1;
      default: ;
    endcase
    case (selB1)
      psel_pkg::CODE1: analogNext[4] = 1'b1;
      psel_pkg::CODE3: lsXtalNext = 1'b1;
      default: ;
    endcase
    case (selB0)
      psel_pkg::CODE1: begin
        padOutNext[psel_pkg::P_B0] = periodicTimer0Out;
        padOeNext[psel_pkg::P_B0] = 1'b1;
      end
      psel_pkg::CODE2: analogNext[3] = 1'b1;
      psel_pkg::CODE3: lsXtalNext = 1'b1;
      default: ;
    endcase
    case (selB4)
      psel_pkg::CODE1: begin
        padOutNext[psel_pkg::P_B4] = clkOutLevel;
        padOeNext[psel_pkg::P_B4] = 1'b1;
      end
      psel_pkg::CODE2: ampNext[psel_pkg::AMP0_OUT] = 1'b1;
      default: ;
    endcase
    case (selB6)
      psel_pkg::CODE1: begin
        padOutNext[psel_pkg::P_B6] = lcdCommon1;
        padOeNext[psel_pkg::P_B6] = 1'b1;
      end
      psel_pkg::CODE2: begin
        padOutNext[psel_pkg::P_B6] = 1'b0;
        padOeNext[psel_pkg::P_B6] = spiDataOe;
      end
      psel_pkg::CODE3: padOeNext[psel_pkg::P_B6] = 1'b0;
      default: ;
    endcase
    case (selB5)
      psel_pkg::CODE1: begin
        padOutNext[psel_pkg::P_B5] = lcdCommon2;
        padOeNext[psel_pkg::P_B5] = 1'b1;
      end
      psel_pkg::CODE2: begin
        padOutNext[psel_pkg::P_B5] = uartTx;
        padOeNext[psel_pkg::P_B5] = 1'b1;
      end
      psel_pkg::CODE3: analogNext[7] = 1'b1;
      default: ;
    endcase
    // SPI clock on port C bit2
    if (selC2 == psel_pkg::CODE1) begin
      padOutNext[psel_pkg::P_C2] = spiClkOut;
      padOeNext[psel_pkg::P_C2] = spiClkOe;
    end
    case (selC1)
      psel_pkg::CODE1: begin
        padOutNext[psel_pkg::P_C1] = spiDataOut;
        padOeNext[psel_pkg::P_C1] = 1'b1;
      end
      psel_pkg::CODE2: hsXtalNext = 1'b1;
      default: ;
    endcase
    case (selC0)
      psel_pkg::CODE1: begin
        padOutNext[psel_pkg::P_C0] = spiChipSelN;
        padOeNext[psel_pkg::P_C0] = 1'b1;
      end
      psel_pkg::CODE2: hsXtalNext = 1'b1;
      default: ;
    endcase
    // Analog, amplifier and crystal pins lose digital drive
    padAnalogNext[psel_pkg::P_A7] = analogNext[2] | ampNext[psel_pkg::AMP1_INV];
    padAnalogNext[psel_pkg::P_A6] = analogNext[0] | ampNext[psel_pkg::AMP1_OUT];
    padAnalogNext[psel_pkg::P_B3] = analogNext[1] | ampNext[psel_pkg::AMP1_NONINV];
    padAnalogNext[psel_pkg::P_B1] = analogNext[4] | (selB1 == psel_pkg::CODE3);
    padAnalogNext[psel_pkg::P_B0] = analogNext[3] | (selB0 == psel_pkg::CODE3);
    padAnalogNext[psel_pkg::P_B4] = ampNext[psel_pkg::AMP0_OUT];
    padAnalogNext[psel_pkg::P_B5] = analogNext[7];
    padAnalogNext[psel_pkg::P_C1] = (selC1 == psel_pkg::CODE2);
    padAnalogNext[psel_pkg::P_C0] = (selC0 == psel_pkg::CODE2);
    padOeNext = padOeNext & ~padAnalogNext;
    gpioInNext = padIn & ~padAnalogNext;
  end

  // Peripheral inputs; idle levels when the pin is elsewhere
  logic uartRxNext, irq0Next, irq1Next, ptck0Next, resetNNext, spiClkInNext, spiDataInNext;
  // UART receive source, port A wins
  assign uartRxNext = (selA0 == psel_pkg::CODE1) ? padIn[psel_pkg::P_A0] :
                      (selB6 == psel_pkg::CODE3) ? padIn[psel_pkg::P_B6] : 1'b1;
  assign irq0Next = (selB0 == psel_pkg::CODE0) && padIn[psel_pkg::P_B0];
  assign irq1Next = ((selB1 == psel_pkg::CODE0) || (selB1 == psel_pkg::CODE2)) &&
                    padIn[psel_pkg::P_B1];
  assign ptck0Next = (selC2 != psel_pkg::CODE1) && padIn[psel_pkg::P_C2];
  assign resetNNext = (selC2 == psel_pkg::CODE1) || padIn[psel_pkg::P_C2];
  assign spiClkInNext = (selC2 == psel_pkg::CODE1) && padIn[psel_pkg::P_C2];
  assign spiDataInNext = (selB6 == psel_pkg::CODE2) ? padIn[psel_pkg::P_B6] : 1'b1;

  // One register stage on every data output
  always_ff @(posedge core_clk) begin
    if (reset) begin
      padOut <= 12'h000;
      padOe <= 12'h000;
      padAnalog <= 12'h000;
      gpioIn <= 12'h000;
      analogEnable <= 8'h00;
      ampEnable <= 4'h0;
      lowspeedCrystalEnable <= 1'b0;
      hsCrystalEnable <= 1'b0;
      uartRx <= 1'b1;
      extIrqLine0 <= 1'b0;
      extIrqLine1 <= 1'b0;
      periodicTimer0ClockIn <= 1'b0;
      extResetPinN <= 1'b1;
      spiClkIn <= 1'b0;
      spiDataIn <= 1'b1;
    end else begin
      padOut <= padOutNext;
      padOe <= padOeNext;
      padAnalog <= padAnalogNext;
      gpioIn <= gpioInNext;
      analogEnable <= analogNext;
      ampEnable <= ampNext;
      lowspeedCrystalEnable <= lsXtalNext;
      hsCrystalEnable <= hsXtalNext;
      uartRx <= uartRxNext;
      extIrqLine0 <= irq0Next;
      extIrqLine1 <= irq1Next;
      periodicTimer0ClockIn <= ptck0Next;
      extResetPinN <= resetNNext;
      spiClkIn <= spiClkInNext;
      spiDataIn <= spiDataInNext;
    end
  end

endmodule // psel_pin_mux
`default_nettype wire

/* psel_pin_mux_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module psel_pin_mux_chk #(
  parameter bit SMALL_VARIANT = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [11:0] padIn,
  input wire logic [11:0] padOut,
  input wire logic [11:0] padOe,
  input wire logic [7:0] analogEnable,
  input wire logic [3:0] ampEnable,
  input wire logic lowspeedCrystalEnable,
  input wire logic stdTimer0Out,
  input wire logic sysClkLevel,
  input wire logic sysClkEnable,
  input wire logic uartRx,
  input wire logic extIrqLine0,
  input wire logic extIrqLine1
);
  logic wrPend;
  logic rdPend;
  logic busHit;
  logic [2:0] busIdx;
  logic [7:0] shadowReg [5];
  // Shadow copy rebuilt from bus traffic, not from the design's registers
  wire logic take = hsel && hready && htrans[1];
  wire logic [7:0] paLo = shadowReg[0];
  wire logic [7:0] paHi = shadowReg[1];
  wire logic [7:0] pbLo = shadowReg[2];
  wire logic [7:0] pbHi = shadowReg[3];
  wire logic [7:0] wrMask = SMALL_VARIANT ? psel_pkg::MASK_SMALL[busIdx] : psel_pkg::MASK_FULL[busIdx];
  wire logic [7:0] rdExp = busHit ? shadowReg[busIdx] : 8'h00;
  wire logic [7:0] anExp = {!SMALL_VARIANT && pbHi[3:2] == 2'h3, 2'h0, pbLo[3:2] == 2'h1,
    pbLo[1:0] == 2'h2, paHi[7:6] == 2'h2, pbLo[7:6] == 2'h1, paHi[5:4] == 2'h1};
  wire logic [3:0] ampExp = {pbHi[1:0] == 2'h2, paHi[5:4] == 2'h2, pbLo[7:6] == 2'h2,
    paHi[7:6] == 2'h3};
  // Writes land at the end of the data phase
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      busHit <= 1'b0;
      busIdx <= 3'h0;
      shadowReg <= '{default: 8'h00};
    end else if (hready) begin
      wrPend <= take && hwrite;
      rdPend <= take && !hwrite;
      busHit <= haddr[1:0] == 2'h0 && haddr < 8'h14;
      busIdx <= haddr[4:2];
      if (wrPend && busHit) begin
        shadowReg[busIdx] <= hwdata[7:0] & wrMask;
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  rd_data_a: assert property (rdPend && hready |-> hrdata == {24'h0, rdExp})
    else $error("select readback differs from written value");
  analog_map_a: assert property (1'b1 |=> analogEnable == $past(anExp))
    else $error("analog channel enables do not match the fields");
  amp_map_a: assert property (1'b1 |=> ampEnable == $past(ampExp))
    else $error("amplifier terminal enables do not match the fields");
  uart_rx_a: assert property (
    1'b1 |=> uartRx == $past(paLo[1:0] == 2'h1 ? padIn[psel_pkg::P_A0] :
    !SMALL_VARIANT && pbHi[5:4] == 2'h3 ? padIn[psel_pkg::P_B6] : 1'b1))
    else $error("receive input not taken from its pin");
  timer_pin_a: assert property (paHi[7:6] == 2'h1 |=>
    padOe[psel_pkg::P_A7] && padOut[psel_pkg::P_A7] == $past(stdTimer0Out))
    else $error("timer output not driven on its pin");
  clk_out_a: assert property (pbHi[1:0] == 2'h1 |=> padOe[psel_pkg::P_B4] &&
    padOut[psel_pkg::P_B4] == $past(sysClkEnable ? sysClkLevel : 1'b1))
    else $error("clock output pin level wrong");
  // interrupt inputs only in I/O codes
  irq_lines_a: assert property (1'b1 |=> {extIrqLine0, extIrqLine1} == $past({
    pbLo[1:0] == 2'h0 && padIn[psel_pkg::P_B0], !pbLo[2] && padIn[psel_pkg::P_B1]}))
    else $error("interrupt input routing wrong");
  xtal_en_a: assert property (((pbLo[1:0] == 2'h3) == (pbLo[3:2] == 2'h3)) |=>
    lowspeedCrystalEnable == $past(pbLo[1:0] == 2'h3))
    else $error("crystal enable does not follow the fields");
  cover property (rdPend && hready && busHit && rdExp != 8'h00);
  cover property (pbHi[1:0] == 2'h1 && !sysClkEnable);
  cover property (pbLo[1:0] == 2'h3);
endmodule // psel_pin_mux_chk
bind psel_pin_mux psel_pin_mux_chk #(.SMALL_VARIANT(SMALL_VARIANT)) i_psel_pin_mux_chk (
  .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .padIn(padIn),
  .padOut(padOut), .padOe(padOe), .analogEnable(analogEnable), .ampEnable(ampEnable),
  .lowspeedCrystalEnable(lowspeedCrystalEnable), .stdTimer0Out(stdTimer0Out),
  .sysClkLevel(sysClkLevel), .sysClkEnable(sysClkEnable), .uartRx(uartRx),
  .extIrqLine0(extIrqLine0), .extIrqLine1(extIrqLine1)
);
`default_nettype wire

/* psel_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
module psel_periph_model (
  input wire logic core_clk,
  input wire logic hold,
  input wire logic [11:0] padOut,
  input wire logic [11:0] padOe,
  output logic [11:0] padIn,
  output logic [11:0] gpioOut,
  output logic [11:0] gpioOe,
  output logic [10:0] periphLvl
);
  integer seed = 40;
  logic [31:0] rndA = 32'h0;
  logic [31:0] rndB = 32'h0;
  // Pin level: our own drive wins, else the outside world keeps changing
  assign padIn = (padOe & padOut) | (~padOe & rndA[11:0]);
  assign gpioOut = rndA[23:12];
  assign periphLvl = {rndA[31:24], rndB[14:12]};
  assign gpioOe = rndB[11:0] & 12'hFE7;
  // Fresh levels each cycle unless the bench quiesces us
  always @(posedge core_clk) begin
    if (!hold) begin
      rndA <= $random(seed);
      rndB <= $random(seed);
    end
  end
endmodule // psel_periph_model
`default_nettype wire

/* psel_pin_mux_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module psel_pin_mux_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hold = 1'b0;
  logic clkEn = 1'b1;
  logic rdPend = 1'b0;
  logic [1:0] code = 2'h0;
  logic [17:0] got;
  logic [17:0] expv;
  logic [7:0] expQ [$];
  logic [7:0] mk [6] = '{8'h3F, 8'hF0, 8'hCF, 8'h03, 8'h3F, 8'h00};
  int failures = 0;
  int num_checks = 0;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic [11:0] padIn, padOut, padOe, gpioOut, gpioOe;
  wire logic [7:0] analogEnable;
  wire logic [3:0] ampEnable;
  wire logic lsXtal, hsXtal, uartRx, irq0, irq1;
  wire logic [10:0] lvl;
  wire logic [11:0] padAnalog, gpioIn;
  wire logic hresp, periodic_timer0_clock_in, rstPinN, sclkIn, sdiIn;
  logic [11:0] anaExp = 12'h000;

  always #25 core_clk = ~core_clk;

  psel_pin_mux i_psel_pin_mux (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .padAnalog(padAnalog), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn),
    .analogEnable(analogEnable),
    .ampEnable(ampEnable), .lowspeedCrystalEnable(lsXtal), .hsCrystalEnable(hsXtal),
    .uartTx(lvl[10]), .stdTimer0Out(lvl[9]), .periodicTimer0Out(lvl[8]), .lcdCommon1(lvl[7]),
    .lcdCommon2(lvl[6]), .sysClkLevel(lvl[5]), .sysClkEnable(clkEn), .spiDataOut(lvl[4]),
    .spiChipSelN(lvl[3]), .spiClkOut(lvl[2]), .spiClkOe(lvl[1]), .spiDataOe(lvl[0]),
    .uartRx(uartRx), .extIrqLine0(irq0), .extIrqLine1(irq1), .periodicTimer0ClockIn(periodic_timer0_clock_in),
    .extResetPinN(rstPinN), .spiClkIn(sclkIn), .spiDataIn(sdiIn)
  );

  psel_periph_model i_psel_periph_model (
    .core_clk(core_clk), .hold(hold), .padOut(padOut), .padOe(padOe), .padIn(padIn),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .periphLvl(lvl)
  );

  task automatic conclude;
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bounded wait for hready; a stuck bus ends the run
  task automatic waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask

  // Single word transfer; ends right after the data phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitRdy();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask

  // Watcher: each finished read data phase takes the oldest note
  always @(posedge core_clk) begin
    if (rdPend && hreadyout === 1'b1) begin
      chk(hrdata, expQ.size() > 0 ? {24'h0, expQ.pop_front()} : 32'hDEADBEEF);
      // Every read response must be OKAY
      chk(32'(hresp), 32'h0);
    end
    if (hreadyout === 1'b1) begin
      rdPend <= hsel && htrans[1] && !hwrite;
    end
  end

  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 8'h00);
    for (int i = 0; i < 6; i++) xfer(1'b1, 8'(i * 4), 8'hFF);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), mk[i]);
    // Read right behind a write to the same place
    xfer(1'b1, 8'h04, 8'h5A);
    rd(8'h04, 8'h50);
    for (int r = 0; r < 8; r++) begin
      code = 2'(r);
      hold <= 1'b1;
      clkEn <= r[2];
      for (int i = 0; i < 5; i++) xfer(1'b1, 8'(i * 4), {4{code}});
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      got = {analogEnable, ampEnable, lsXtal, hsXtal, uartRx, irq0, irq1,
        code == 2'h1 && padOut[6]};
      expv = {code == 2'h1 ? 8'h13 : code == 2'h2 ? 8'h0C : 8'h00,
        code == 2'h2 ? 4'hE : code == 2'h3 ? 4'h1 : 4'h0, code == 2'h3, code == 2'h2,
        code == 2'h1 ? padIn[0] : 1'b1, code == 2'h0 && padIn[3], !code[0] && padIn[4],
        code == 2'h1 && (!clkEn || lvl[5])};
      // every field code, all fields at once: enables and peripheral inputs
      chk(32'(got), 32'(expv));
      anaExp = code == 2'h1 ? 12'h032 : code == 2'h2 ? 12'h66E :
        code == 2'h3 ? 12'h01C : 12'h000;
      // analog pad mask, port C bit2 inputs
      chk(32'({padAnalog, gpioIn, periodic_timer0_clock_in, rstPinN, sclkIn, sdiIn}),
        32'({anaExp, padIn & ~anaExp, code != 2'h1 && padIn[11], code == 2'h1 || padIn[11],
        code == 2'h1 && padIn[11], 1'b1}));
      // serial output pads on port C
      chk(32'({padOe[10:9], padOut[10:9]}),
        32'(code == 2'h1 ? {2'h3, lvl[4], lvl[3]} : code == 2'h2 ? {2'h0, gpioOut[10:9]} :
        {gpioOe[10:9], gpioOut[10:9]}));
      @(posedge core_clk);
      hold <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
    conclude();
  end
endmodule // psel_pin_mux_tb
`default_nettype wire
